/* File: baud_prescaler.sv */
`timescale 1ns/1ns
// divides clk by (divisor+1), reload restarts count
module baud_prescaler #(
    parameter int WIDTH = 12
) (
    input  wire logic             clk_in,
    input  wire logic             nrst_in,
    input  wire logic             reload_in,
    input  wire logic [WIDTH-1:0] divisor_in,
    output logic                  tick_out
);
    logic [WIDTH-1:0] count_ff;   // down counter
    logic             tick_ff;    // registered tick
    wire              at_zero = (count_ff == '0);

    // reload wins over count so a new divisor acts at once
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            count_ff <= '0;
            tick_ff  <= 1'b0;
        end else if (reload_in) begin
            count_ff <= divisor_in;
            tick_ff  <= 1'b0;
        end else begin
            count_ff <= at_zero ? divisor_in : count_ff - 1'b1;
            tick_ff  <= at_zero;
        end
    end
    assign tick_out = tick_ff;
endmodule

/* File: serial_peer.sv */
`timescale 1ns/1ns
// remote async peer: drives the receive line, times and samples the transmit line
module serial_peer (
    // clock
    input  wire logic clk_in,
    // line side
    input  wire logic txd_in,
    output logic      rxd_out
);
    int unsigned cyc;  // free-running cycle count, used to time frame starts

    // cycle counter
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
    end

    // line rests at mark level until a frame is sent
    initial begin
        cyc = 0;
        rxd_out = 1'b1;
    end

    // start bit, then nb bits lsb first (caller adds parity and stop bits)
    task automatic send(input logic [15:0] bits, input int nb, input int per);
        for (int i = -1; i <= nb; i++) begin
            @(posedge clk_in);
            rxd_out <= (i < 0) ? 1'b0 : (i == nb) ? 1'b1 : bits[i];
            // hold each bit, the start bit and the trailing mark bit included, for per cycles in all
            repeat (per - 1) @(posedge clk_in);
        end
    endtask

    // waits for a start edge, samples nb bits mid-bit; t0 is the start cycle
    task automatic recv(input int nb, input int per, output logic [15:0] v,
                        output int unsigned t0);
        v = '0;
        @(negedge txd_in);
        // read the counter away from the edge so both frames are timed alike
        @(negedge clk_in);
        t0 = cyc;
        repeat (per / 2) @(posedge clk_in);
        for (int i = 0; i < nb; i++) begin
            repeat (per) @(posedge clk_in);
            v[i] = txd_in;
        end
    endtask
endmodule

/* File: usart_control_and_baud_regs_bench.sv */
`timescale 1ns/1ns
`define CHK(got, exp) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        n_mismatch++; \
        $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); \
    end \
end
module usart_control_and_baud_regs_bench;
    // clock, reset
    logic        clk_in;
    logic        nrst_in;
    // register port
    logic [2:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    // cpu flag and pins
    logic        global_ie;
    logic        rxd;
    logic        sclk;
    logic        txd;
    logic        txd_oe_n;
    logic        rx_owns;
    logic        tx_done_irq;
    logic        buf_empty_irq;
    // bookkeeping
    int          n_mismatch;
    int          tests_run;
    int          per;
    logic [7:0]  v8;
    logic [15:0] v16;
    int unsigned t0;
    int unsigned t1;
    // transmit cases: format, enable, data, captured bits, expected, frame bits
    logic [7:0]  c_fmt [9] = '{8'h86, 8'h8E, 8'hA6, 8'hB6, 8'h86, 8'h80, 8'h82, 8'h84, 8'h86};
    logic [7:0]  c_en [9]  = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h0D, 8'h08, 8'h08, 8'h08, 8'h08};
    logic [7:0]  c_dat [9] = '{8'h5A, 8'h5A, 8'h5B, 8'h5B, 8'h00, 8'hE0, 8'hC1, 8'h81, 8'h3C};
    logic [15:0] c_exp [9] = '{16'h005A, 16'h005A, 16'h015B, 16'h005B, 16'h0100,
                               16'h0000, 16'h0001, 16'h0001, 16'h003C};
    int          c_nb [9]   = '{8, 8, 9, 9, 9, 5, 6, 7, 8};
    int          c_bits [9] = '{10, 11, 11, 11, 11, 7, 8, 9, 10};

    usart_ctrl dut (
        .clk_in            (clk_in),
        .nrst_in           (nrst_in),
        .addr_in           (addr),
        .wdata_in          (wdata),
        .wr_in             (wr),
        .rd_in             (rd),
        .rdata_out         (rdata),
        .global_ie_in      (global_ie),
        .rxd_in            (rxd),
        .sclk_in           (sclk),
        .txd_out           (txd),
        .txd_oe_n_out      (txd_oe_n),
        .rx_owns_pin_out   (rx_owns),
        .sclk_sync_out     (),
        .tx_done_irq_out   (tx_done_irq),
        .buf_empty_irq_out (buf_empty_irq)
    );

    serial_peer peer (
        .clk_in  (clk_in),
        .txd_in  (txd),
        .rxd_out (rxd)
    );

    // 25 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    // one-cycle write strobe, released after the edge that takes it
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask

    // n back-to-back reads; answer of the last one sampled mid-cycle
    task automatic rd_reg(input logic [2:0] a, input int n, output logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        repeat (n) @(posedge clk_in);
        rd <= 1'b0;
        @(negedge clk_in);
        d = rdata;
    endtask

    // polls a status flag with a bounded count
    task automatic wait_flag(input int b);
        logic [7:0] st;
        st = '0;
        for (int i = 0; i < 400 && st[b] !== 1'b1; i++) rd_reg(usart_ctrl_pkg::ADDR_STATUS, 1, st);
    endtask

    // data writes only once the buffer has room, else they are dropped
    task automatic tx_byte(input logic [7:0] d);
        wait_flag(usart_ctrl_pkg::ST_BUFEMP);
        wr_reg(usart_ctrl_pkg::ADDR_DATA, d);
    endtask

    // verdict and end of run
    task automatic close_out();
        $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog, far beyond the expected run of some 7000 cycles
    initial begin
        repeat (60000) @(posedge clk_in);
        n_mismatch++;
        close_out();
    end

    // main sequence
    initial begin
        {addr, wdata, wr, rd, global_ie, sclk, nrst_in} = '0;
        n_mismatch = 0;
        tests_run = 0;
        repeat (4) @(posedge clk_in);
        nrst_in <= 1'b1;
        rd_reg(usart_ctrl_pkg::ADDR_ENABLE, 1, v8);
        `CHK(v8, 8'h00)
        `CHK(txd_oe_n, 1'b1)
        rd_reg(usart_ctrl_pkg::ADDR_SHARED, 1, v8);
        `CHK(v8, 8'h00)
        rd_reg(usart_ctrl_pkg::ADDR_SHARED, 2, v8);
        `CHK(v8, 8'h86)
        // reserved bits zero; top bit zero routes to baud high
        wr_reg(usart_ctrl_pkg::ADDR_SHARED, 8'h0A);
        rd_reg(usart_ctrl_pkg::ADDR_SHARED, 1, v8);
        `CHK(v8, 8'h0A)
        rd_reg(usart_ctrl_pkg::ADDR_SHARED, 2, v8);
        `CHK(v8, 8'h86)
        // unmapped index: writes dropped, reads zero
        wr_reg(3'h7, 8'hFF);
        rd_reg(3'h7, 1, v8);
        `CHK(v8, 8'h00)
        // divisor set while idle: 2 cycles a tick, 32 a bit
        wr_reg(usart_ctrl_pkg::ADDR_SHARED, 8'h00);
        wr_reg(usart_ctrl_pkg::ADDR_BAUD_LO, 8'h01);
        // polarity kept zero in async; each case sends two frames back to back
        for (int i = 0; i < 9; i++) begin
            per = (i == 8) ? 16 : 32;
            wr_reg(usart_ctrl_pkg::ADDR_STATUS, (i == 8) ? 8'h42 : 8'h40);
            wr_reg(usart_ctrl_pkg::ADDR_SHARED, c_fmt[i]);
            wr_reg(usart_ctrl_pkg::ADDR_ENABLE, c_en[i]);
            fork
                begin
                    tx_byte(c_dat[i]);
                    tx_byte(c_dat[i]);
                end
                begin
                    peer.recv(c_nb[i], per, v16, t0);
                    peer.recv(c_nb[i], per, v16, t1);
                end
            join
            `CHK(v16, c_exp[i])
            `CHK(t1 - t0, c_bits[i] * per)
            wait_flag(usart_ctrl_pkg::ST_TXDONE);
        end
        // interrupt requests need enable, global flag and source flag together
        wr_reg(usart_ctrl_pkg::ADDR_ENABLE, 8'h48);
        global_ie <= 1'b1;
        repeat (3) @(posedge clk_in);
        `CHK(tx_done_irq, 1'b1)
        `CHK(buf_empty_irq, 1'b0)
        global_ie <= 1'b0;
        repeat (3) @(posedge clk_in);
        `CHK(tx_done_irq, 1'b0)
        wr_reg(usart_ctrl_pkg::ADDR_ENABLE, 8'h28);
        global_ie <= 1'b1;
        repeat (3) @(posedge clk_in);
        `CHK(buf_empty_irq, 1'b1)
        wr_reg(usart_ctrl_pkg::ADDR_STATUS, 8'h40);
        wr_reg(usart_ctrl_pkg::ADDR_ENABLE, 8'h48);
        repeat (3) @(posedge clk_in);
        `CHK(tx_done_irq, 1'b0)
        global_ie <= 1'b0;
        // disable mid-frame: pin kept until the frame drains
        wr_reg(usart_ctrl_pkg::ADDR_ENABLE, 8'h08);
        tx_byte(8'h55);
        fork
            peer.recv(8, 32, v16, t0);
            begin
                repeat (60) @(posedge clk_in);
                wr_reg(usart_ctrl_pkg::ADDR_ENABLE, 8'h00);
                repeat (4) @(posedge clk_in);
                `CHK(txd_oe_n, 1'b0)
            end
        join
        `CHK(v16, 16'h0055)
        repeat (64) @(posedge clk_in);
        `CHK(txd_oe_n, 1'b1)
        // receive: good frame, then parity error, then disable flushes
        wr_reg(usart_ctrl_pkg::ADDR_SHARED, 8'hA6);
        wr_reg(usart_ctrl_pkg::ADDR_ENABLE, 8'h10);
        repeat (3) @(posedge clk_in);
        `CHK(rx_owns, 1'b1)
        peer.send(16'h02A5, 10, 32);
        rd_reg(usart_ctrl_pkg::ADDR_STATUS, 1, v8);
        `CHK(v8 & 8'h9C, 8'h80)
        rd_reg(usart_ctrl_pkg::ADDR_DATA, 1, v8);
        `CHK(v8, 8'hA5)
        peer.send(16'h025B, 10, 32);
        rd_reg(usart_ctrl_pkg::ADDR_STATUS, 1, v8);
        `CHK(v8 & 8'h9C, 8'h84)
        wr_reg(usart_ctrl_pkg::ADDR_ENABLE, 8'h00);
        rd_reg(usart_ctrl_pkg::ADDR_STATUS, 1, v8);
        `CHK(v8 & 8'h9C, 8'h00)
        `CHK(rx_owns, 1'b0)
        // nine-bit receive: ninth bit read before the low byte
        wr_reg(usart_ctrl_pkg::ADDR_SHARED, 8'h86);
        wr_reg(usart_ctrl_pkg::ADDR_ENABLE, 8'h14);
        peer.send(16'h033C, 10, 32);
        rd_reg(usart_ctrl_pkg::ADDR_ENABLE, 1, v8);
        `CHK(v8, 8'h16)
        rd_reg(usart_ctrl_pkg::ADDR_DATA, 1, v8);
        `CHK(v8, 8'h3C)
        // sync mode, polarity zero: bits change after each serial clock rise
        wr_reg(usart_ctrl_pkg::ADDR_SHARED, 8'hC6);
        wr_reg(usart_ctrl_pkg::ADDR_ENABLE, 8'h08);
        wr_reg(usart_ctrl_pkg::ADDR_DATA, 8'hA5);
        v16 = '0;
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_in);
            sclk <= 1'b1;
            repeat (4) @(posedge clk_in);
            sclk <= 1'b0;
            repeat (4) @(negedge clk_in);
            v16[i] = txd;
        end
        `CHK(v16, 16'h034A)
        close_out();
    end
endmodule

/* File: usart_ctrl.sv */
`timescale 1ns/1ns
// How it works
// - tx-done irq needs enable, global, flag
// - empty irq needs enable, global, flag
// - receiver enable takes over rx pin
// - receiver disable flushes buffer and errors
// - transmitter enable takes over tx pin
// - tx disable waits until all drained
// - ninth received bit readable separately
// - ninth transmit bit sent from register
// - frame format top bit reads one
// - mode bit: zero async, one sync
// - parity field: off, reserved, even, odd
// - parity appended on tx, checked on rx
// - stop select one or two, tx only
// - size code gives five to nine bits
// - clock polarity picks sync edges
// - baud high select bit reads zero
// - twelve bit divisor from high, low
// - low byte write reloads prescaler
// - shared write routed by top bit
// - back-to-back read returns frame format
// - double speed halves ratio in async
module usart_ctrl (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    // register port
    input  wire logic [2:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    // cpu global interrupt flag
    input  wire logic       global_ie_in,
    // serial pins
    input  wire logic       rxd_in,
    input  wire logic       sclk_in,
    output logic            txd_out,
    output logic            txd_oe_n_out,
    output logic            rx_owns_pin_out,
    output logic            sclk_sync_out,
    // interrupt requests
    output logic            tx_done_irq_out,
    output logic            buf_empty_irq_out
);
    // ---- registers ----
    logic [7:0]  enable_ff;      // enable control
    logic [7:0]  format_ff;      // frame format
    logic [3:0]  baud_hi_ff;     // divisor high
    logic [7:0]  baud_lo_ff;     // divisor low
    logic        dblspd_ff;      // double speed
    logic        txdone_ff;      // tx done flag
    logic        bufemp_ff;      // tx buffer empty
    logic [8:0]  tx_buf_ff;      // tx buffer word
    logic [11:0] tx_shift_ff;    // tx frame shifter
    logic [3:0]  tx_left_ff;     // tx bits remaining
    logic        tx_busy_ff;     // shifter active
    logic        tx_pin_ff;      // pin taken by tx
    logic        txd_ff;         // tx line level
    logic [8:0]  rx_data_ff;     // rx buffer word
    logic        rxc_ff;         // rx data ready
    logic        frerr_ff;       // frame error
    logic        ovrun_ff;       // overrun
    logic        parerr_ff;      // parity error
    logic [7:0]  rdata_ff;       // read data
    logic        prev_rd_sh_ff;  // shared read last cycle
    logic        irq_tx_ff;
    logic        irq_ud_ff;
    // pin synchronisers: stage one feeds stage two only
    logic        rxd_s1_ff, rxd_s2_ff, sclk_s1_ff, sclk_s2_ff, sclk_d_ff;

    // ---- decode ----
    wire wr_data   = wr_in && (addr_in == usart_ctrl_pkg::ADDR_DATA);
    wire wr_status = wr_in && (addr_in == usart_ctrl_pkg::ADDR_STATUS);
    wire wr_enable = wr_in && (addr_in == usart_ctrl_pkg::ADDR_ENABLE);
    wire wr_shared = wr_in && (addr_in == usart_ctrl_pkg::ADDR_SHARED);
    wire wr_baudlo = wr_in && (addr_in == usart_ctrl_pkg::ADDR_BAUD_LO);
    wire rd_data   = rd_in && (addr_in == usart_ctrl_pkg::ADDR_DATA);
    wire rd_shared = rd_in && (addr_in == usart_ctrl_pkg::ADDR_SHARED);
    wire wr_format = wr_shared && wdata_in[usart_ctrl_pkg::FF_SEL];
    wire wr_baudhi = wr_shared && !wdata_in[usart_ctrl_pkg::FF_SEL];

    wire rx_en = enable_ff[usart_ctrl_pkg::EN_RX_ON];
    wire tx_en = enable_ff[usart_ctrl_pkg::EN_TX_ON];
    // mode bit picks async or sync
    wire sync_mode = format_ff[usart_ctrl_pkg::FF_SYNC];
    wire [1:0] par_mode = format_ff[usart_ctrl_pkg::FF_PM_HI:usart_ctrl_pkg::FF_PM_LO];
    wire [2:0] csz = {enable_ff[usart_ctrl_pkg::EN_CSZ2],
                      format_ff[usart_ctrl_pkg::FF_CSZ_HI:usart_ctrl_pkg::FF_CSZ_LO]};
    // data bits per frame, reserved codes fall back to 8
    wire [3:0] nbits = (csz == 3'h7) ? 4'h9 :
                       csz[2]        ? 4'h8 : {2'h0, csz[1:0]} + 4'h5;
    wire [11:0] divisor = {baud_hi_ff, baud_lo_ff};
    // ratio 8 only in async with double speed
    wire [4:0] ratio = (dblspd_ff && !sync_mode) ? usart_ctrl_pkg::OVS_DOUBLE
                                              : usart_ctrl_pkg::OVS_NORMAL;

    // ---- baud prescaler ----
    wire presc_tick;
    baud_prescaler #(.WIDTH(12)) u_presc (
        .clk_in     (clk_in),
        .nrst_in    (nrst_in),
        .reload_in  (wr_baudlo),
        .divisor_in (divisor),
        .tick_out   (presc_tick)
    );
    logic [4:0] ovs_ff;  // oversample count
    wire ovs_wrap = presc_tick && (ovs_ff >= ratio - 5'h01);
    // sync edges: pol 0 shift on rise, sample on fall
    wire sclk_rise = sclk_s2_ff && !sclk_d_ff;
    wire sclk_fall = !sclk_s2_ff && sclk_d_ff;
    wire pol = format_ff[usart_ctrl_pkg::FF_POL];
    wire tx_step = sync_mode ? (pol ? sclk_fall : sclk_rise) : ovs_wrap;
    wire rx_step = sync_mode ? (pol ? sclk_rise : sclk_fall) : ovs_wrap;

    // parity over data bits, masked to frame size
    wire [8:0] bit_mask = 9'h1FF >> (4'h9 - nbits);
    wire tx_par = ^(tx_buf_ff & bit_mask) ^ par_mode[0];
    // frame build: start, data incl. ninth bit, parity, stops
    // stop ones come from the fill term below, not from here
    wire [11:0] tx_frame = {3'h0, tx_buf_ff & bit_mask};
    // next frame loads on the step that ends the last stop bit
    wire tx_last = tx_busy_ff && (tx_left_ff == 4'h1);
    wire tx_load = tx_pin_ff && !bufemp_ff && tx_step && (!tx_busy_ff || tx_last);
    wire par_on  = par_mode[1];
    wire [3:0] tx_len = nbits + {3'h0, par_on} + {3'h0, format_ff[usart_ctrl_pkg::FF_STOP]}
                      + 4'h2;

    // oversample counter
    always_ff @(posedge clk_in) begin
        if (!nrst_in || wr_baudlo)
            ovs_ff <= 5'h00;
        else if (presc_tick)
            ovs_ff <= ovs_wrap ? 5'h00 : ovs_ff + 5'h01;
    end

    // pin synchronisers
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            {rxd_s1_ff, rxd_s2_ff} <= 2'h3;
            {sclk_s1_ff, sclk_s2_ff, sclk_d_ff} <= 3'h0;
        end else begin
            rxd_s1_ff  <= rxd_in;
            rxd_s2_ff  <= rxd_s1_ff;
            sclk_s1_ff <= sclk_in;
            sclk_s2_ff <= sclk_s1_ff;
            sclk_d_ff  <= sclk_s2_ff;
        end
    end

    // control registers
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            enable_ff  <= usart_ctrl_pkg::EN_RESET;
            format_ff  <= usart_ctrl_pkg::FF_RESET;
            baud_hi_ff <= 4'h0;
            baud_lo_ff <= 8'h00;
            dblspd_ff  <= 1'b0;
        end else begin
            // rx ninth bit is read-only, keep hardware copy
            if (wr_enable)
                enable_ff <= {wdata_in[7:2], enable_ff[1], wdata_in[0]};
            // top bit always stored as one
            if (wr_format)
                format_ff <= wdata_in | 8'h80;
            if (wr_baudhi)
                baud_hi_ff <= wdata_in[3:0];
            if (wr_baudlo)
                baud_lo_ff <= wdata_in;
            if (wr_status)
                dblspd_ff <= wdata_in[usart_ctrl_pkg::ST_DBLSPD];
        end
    end

    // transmitter: buffer, shifter, pin ownership
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            bufemp_ff   <= 1'b1;
            txdone_ff   <= 1'b0;
            tx_buf_ff   <= 9'h000;
            tx_shift_ff <= 12'hFFF;
            tx_left_ff  <= 4'h0;
            tx_busy_ff  <= 1'b0;
            tx_pin_ff   <= 1'b0;
            txd_ff      <= 1'b1;
        end else begin
            // enable takes pin; release only when drained
            if (tx_en)
                tx_pin_ff <= 1'b1;
            else if (!tx_busy_ff && bufemp_ff)
                tx_pin_ff <= 1'b0;
            // writes only accepted while buffer empty
            if (wr_data && bufemp_ff) begin
                tx_buf_ff <= {enable_ff[usart_ctrl_pkg::EN_TX_BIT9], wdata_in};
                bufemp_ff <= 1'b0;
            end else if (tx_load) begin
                bufemp_ff <= 1'b1;
            end
            if (tx_load) begin
                tx_shift_ff <= (tx_frame << 1)
                             | ({11'h0, par_on & tx_par} << (nbits + 4'h1))
                             | ~(12'hFFF >> (4'hB - nbits - {3'h0, par_on}));
                tx_left_ff  <= tx_len;
                tx_busy_ff  <= 1'b1;
                txd_ff      <= 1'b0;
            end else if (tx_busy_ff && tx_step) begin
                txd_ff      <= tx_shift_ff[1];
                tx_shift_ff <= {1'b1, tx_shift_ff[11:1]};
                tx_left_ff  <= tx_left_ff - 4'h1;
                if (tx_left_ff == 4'h1) begin
                    tx_busy_ff <= 1'b0;
                    txd_ff     <= 1'b1;
                end
            end
            // done flag set wins over write-one clear
            if (tx_last && tx_step && bufemp_ff)
                txdone_ff <= 1'b1;
            else if (wr_status && wdata_in[usart_ctrl_pkg::ST_TXDONE])
                txdone_ff <= 1'b0;
        end
    end

    // receiver: bit count and capture
    logic [3:0]  rx_cnt_ff;
    logic [10:0] rx_sh_ff;
    logic        rx_busy_ff;
    wire [3:0] rx_len = nbits + {3'h0, par_on} + 4'h1;
    // done on the stop sample itself, so a following start is not missed
    wire rx_done = rx_busy_ff && rx_step && (rx_cnt_ff == rx_len - 4'h1);
    wire [10:0] rx_word = {rxd_s2_ff, rx_sh_ff[10:1]} >> (4'hB - rx_len);
    wire [8:0] rx_bits = rx_word[8:0] & bit_mask;
    wire rx_par_bad = par_on && ((^rx_bits ^ par_mode[0]) != rx_word[nbits]);
    always_ff @(posedge clk_in) begin
        if (!nrst_in || !rx_en) begin
            // disable flushes buffer and error flags
            rx_cnt_ff  <= 4'h0;
            rx_sh_ff   <= 11'h000;
            rx_busy_ff <= 1'b0;
            rxc_ff     <= 1'b0;
            frerr_ff   <= 1'b0;
            ovrun_ff   <= 1'b0;
            parerr_ff  <= 1'b0;
            rx_data_ff <= 9'h000;
        end else begin
            if (!rx_busy_ff && rx_step && !rxd_s2_ff) begin
                rx_busy_ff <= 1'b1;
                rx_cnt_ff  <= 4'h0;
            end else if (rx_busy_ff && rx_step) begin
                rx_sh_ff  <= {rxd_s2_ff, rx_sh_ff[10:1]};
                rx_cnt_ff <= rx_cnt_ff + 4'h1;
                if (rx_done)
                    rx_busy_ff <= 1'b0;
            end
            if (rx_done) begin
                // ninth bit held with the word
                rx_data_ff <= rx_bits;
                frerr_ff   <= !rxd_s2_ff;
                parerr_ff  <= rx_par_bad;
                ovrun_ff   <= rxc_ff && !rd_data;
                rxc_ff     <= 1'b1;
            end else if (rd_data) begin
                rxc_ff <= 1'b0;
            end
        end
    end

    // read mux and interrupt outputs
    wire [7:0] status_rd = {rxc_ff, txdone_ff, bufemp_ff, frerr_ff, ovrun_ff, parerr_ff,
                            dblspd_ff, 1'b0};
    wire [7:0] enable_rd = {enable_ff[7:2], rx_data_ff[8], enable_ff[0]};
    // read right after a shared read returns format
    // baud high reads select bit zero
    wire [7:0] shared_rd = prev_rd_sh_ff ? format_ff : {4'h0, baud_hi_ff};
    wire [7:0] rd_mux =
        (addr_in == usart_ctrl_pkg::ADDR_DATA)    ? rx_data_ff[7:0] :
        (addr_in == usart_ctrl_pkg::ADDR_STATUS)  ? status_rd :
        (addr_in == usart_ctrl_pkg::ADDR_ENABLE)  ? enable_rd :
        (addr_in == usart_ctrl_pkg::ADDR_SHARED)  ? shared_rd :
        (addr_in == usart_ctrl_pkg::ADDR_BAUD_LO) ? baud_lo_ff : 8'h00;
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            rdata_ff      <= 8'h00;
            prev_rd_sh_ff <= 1'b0;
            irq_tx_ff     <= 1'b0;
            irq_ud_ff     <= 1'b0;
        end else begin
            rdata_ff      <= rd_in ? rd_mux : 8'h00;
            prev_rd_sh_ff <= rd_shared;
            irq_tx_ff <= enable_ff[usart_ctrl_pkg::EN_TXDONE_IE] && global_ie_in && txdone_ff;
            irq_ud_ff <= enable_ff[usart_ctrl_pkg::EN_BUFEMP_IE] && global_ie_in && bufemp_ff;
        end
    end

    assign rdata_out         = rdata_ff;
    assign txd_out           = txd_ff;
    assign txd_oe_n_out      = !tx_pin_ff;
    assign rx_owns_pin_out   = rx_en;
    assign sclk_sync_out     = sclk_s2_ff;
    assign tx_done_irq_out   = irq_tx_ff;
    assign buf_empty_irq_out = irq_ud_ff;

    // ---- assertions ----
    a_done_irq_gate: assert property (@(posedge clk_in) disable iff (!nrst_in)
        tx_done_irq_out |-> $past(txdone_ff && global_ie_in && enable_ff[6]))
        else $error("tx done irq without cause");
    a_empty_irq_gate: assert property (@(posedge clk_in) disable iff (!nrst_in)
        buf_empty_irq_out == $past(bufemp_ff && global_ie_in && enable_ff[5]))
        else $error("buffer empty irq mismatch");
    a_rx_flush_flags: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !rx_en |=> !rxc_ff && !frerr_ff && !ovrun_ff && !parerr_ff)
        else $error("rx flags survive disable");
    a_tx_pin_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (tx_busy_ff && !tx_en) |=> !txd_oe_n_out)
        else $error("tx pin released mid frame");
    a_format_top_one: assert property (@(posedge clk_in) disable iff (!nrst_in)
        format_ff[7])
        else $error("format top bit not one");
    a_shared_seq_read: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (rd_shared ##1 rd_shared) |=> rdata_out == $past(format_ff))
        else $error("second shared read not format");
    a_baud_hi_read: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (!prev_rd_sh_ff && rd_shared) |=> rdata_out[7:4] == 4'h0)
        else $error("baud high top bits not zero");
    a_shared_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wr_baudhi |=> baud_hi_ff == $past(wdata_in[3:0]) && $stable(format_ff))
        else $error("shared write misrouted");
endmodule

/* File: usart_ctrl_pkg.sv */
package usart_ctrl_pkg;
    // register indices on the plain port (chosen map)
    localparam logic [2:0] ADDR_DATA    = 3'h0;
    localparam logic [2:0] ADDR_STATUS  = 3'h1;
    localparam logic [2:0] ADDR_ENABLE  = 3'h2;
    localparam logic [2:0] ADDR_SHARED  = 3'h3;
    localparam logic [2:0] ADDR_BAUD_LO = 3'h4;
    // enable control bit positions
    localparam int EN_TXDONE_IE = 6;
    localparam int EN_BUFEMP_IE = 5;
    localparam int EN_RX_ON     = 4;
    localparam int EN_TX_ON     = 3;
    localparam int EN_CSZ2      = 2;
    localparam int EN_RX_BIT9   = 1;
    localparam int EN_TX_BIT9   = 0;
    // frame format bit positions
    localparam int FF_SEL  = 7;
    localparam int FF_SYNC = 6;
    localparam int FF_PM_HI = 5;
    localparam int FF_PM_LO = 4;
    localparam int FF_STOP = 3;
    localparam int FF_CSZ_HI = 2;
    localparam int FF_CSZ_LO = 1;
    localparam int FF_POL  = 0;
    // status bit positions
    localparam int ST_RXC  = 7;
    localparam int ST_TXDONE = 6;
    localparam int ST_BUFEMP = 5;
    localparam int ST_FRERR  = 4;
    localparam int ST_OVRUN  = 3;
    localparam int ST_PARERR = 2;
    localparam int ST_DBLSPD = 1;
    // reset values
    localparam logic [7:0] FF_RESET   = 8'h86;
    localparam logic [7:0] EN_RESET   = 8'h00;
    localparam logic [7:0] STAT_RESET = 8'h20;
    // oversampling ratios and parity modes
    localparam logic [4:0] OVS_NORMAL = 5'h10;
    localparam logic [4:0] OVS_DOUBLE = 5'h08;
    localparam logic [1:0] PAR_OFF  = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h2;
    localparam logic [1:0] PAR_ODD  = 2'h3;
endpackage
